// file: include/arseq_map.vh
// register offsets, field positions and timing constants of the reclose sequencer
`ifndef ARSEQ_MAP_VH
`define ARSEQ_MAP_VH
// word indices (byte address = 4 * index)
`define ARSEQ_IDX_CTRL 5'h00
`define ARSEQ_IDX_RECLAIM 5'h01
`define ARSEQ_IDX_TICKDIV 5'h02
`define ARSEQ_IDX_STATUS 5'h03
`define ARSEQ_IDX_START0 5'h04
`define ARSEQ_IDX_DEAD0 5'h08
`define ARSEQ_IDX_DISCR0 5'h0d
`define ARSEQ_IDX_SRECL0 5'h12
`define ARSEQ_IDX_SHOTEN0 5'h17
`define ARSEQ_IDX_LAST 5'h1b
// control fields
`define ARSEQ_CTRL_ENABLE 0
`define ARSEQ_CTRL_SHOT_RECL 1
`define ARSEQ_CTRL_AUTO_BRK 2
`define ARSEQ_CTRL_OBJ1_LSB 4
`define ARSEQ_CTRL_OBJ2_LSB 8
// reset values
`define ARSEQ_RST_CTRL 16'h0010
`define ARSEQ_RST_TICKDIV 16'h9c3f
`define ARSEQ_RST_SETTING 16'h000a
// timing
`define ARSEQ_CLK_KHZ 40000
`define ARSEQ_FT_HOLD_MS 500
`define ARSEQ_NSHOT 5
`define ARSEQ_NO_SHOT 3'h7
`endif

// file: logic/arseq_core.v
// breaker auto-reclose sequencer with apb settings and status
//
// Notes on behaviour
// R01: five shots, each with own timings; any of four lines may trigger.
// R02: of several active lines only the highest priority is followed.
// R03: enabled but no shot for the line gives final trip.
// R04: per-line start delays; only the top-priority line's delay is acted on, expiries of lower lines are not.
// R05: a higher-priority line replaces the running start delay.
// R06: after start delay open breaker if closed, then dead time.
// R07: dead time expiry commands close, starts discrimination time.
// R08: critical in dead or discrimination time trips and locks; manual close unlocks.
// R09: critical is ignored while no sequence runs.
// R10: reclaim follows discrimination; a request there advances the shot.
// R11: reclaim expiry without request returns to ready at shot one.
// R12: option picks per-shot or common reclaim time.
// R13: manual close enters reclaim; requests ignored until it ends.
// R14: manual open stops a sequence, breaker left open.
// R15: breaker failure or foreign operation aborts the sequence.
// R16: second breaker when selected or last closed; switch when open.
// R17: blocked shots skipped; no shot left gives final trip.
// R18: later first shot uses previous shot discrimination as start delay.
// R19: shot active flag set at start delay end, moved or cleared.
// R20: running flag from breaker open until close command.
// R21: per-line and critical final-trip flags self-clear after 0.5 s.
// R22: close withheld while close blocking is active.
// R23: all timers count a common tick and clear on reset; the final-trip hold counts clock cycles.
// R24: protection and breaker inputs registered once before use.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "arseq_map.vh"
module arseq_core #(
    parameter [24:0] FT_HOLD_CYC = `ARSEQ_FT_HOLD_MS * `ARSEQ_CLK_KHZ
) (
    input wire clk_in,
    input wire arst_n_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [31:0] paddr_in,
    input wire [31:0] pwdata_in,
    output wire pready_out,
    output reg [31:0] prdata_out,
    output reg pslverr_out,
    input wire reclose_request_one_in,
    input wire reclose_request_two_in,
    input wire reclose_request_three_in,
    input wire reclose_request_four_in,
    input wire critical_request_in,
    input wire breaker_one_closed_in,
    input wire breaker_two_closed_in,
    input wire manual_open_in,
    input wire manual_close_in,
    input wire breaker_fail_in,
    input wire foreign_operation_in,
    input wire second_breaker_select_input_in,
    input wire [4:0] shot_block_in,
    input wire close_block_in,
    output reg open_cmd_out,
    output reg close_cmd_out,
    output reg second_breaker_out,
    output reg [4:0] shot_active_out,
    output reg running_out,
    output reg [4:0] final_trip_out,
    output reg locked_out
);
    //------------------------------------------------------------
    // states
    //------------------------------------------------------------
    localparam [7:0] ST_IDLE = 8'h01;
    localparam [7:0] ST_START = 8'h02;
    localparam [7:0] ST_OPEN = 8'h04;
    localparam [7:0] ST_DEAD = 8'h08;
    localparam [7:0] ST_CLOSE = 8'h10;
    localparam [7:0] ST_DISCR = 8'h20;
    localparam [7:0] ST_RECL = 8'h40;
    localparam [7:0] ST_LOCK = 8'h80;

    // first shot at or after 'from' whose bit is set; none gives the no-shot code
    function [2:0] next_shot;
        input [4:0] en;
        input [2:0] from;
        integer i;
        begin
            next_shot = `ARSEQ_NO_SHOT;
            for (i = 4; i >= 0; i = i - 1) begin
                if (en[i] && (i >= from)) begin
                    next_shot = i[2:0];
                end
            end
        end
    endfunction

    //------------------------------------------------------------
    // input sampling
    //------------------------------------------------------------
    reg [3:0] req_q;
    reg crit_q, b1c_q, b2c_q, mopen_q, mclose_q, fail_q, foreign_q, sel_in_q, cblk_q;
    reg [4:0] sblk_q;
    // one register stage keeps every decision on a stable copy
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            req_q <= 4'h0;
            crit_q <= 1'b0;
            b1c_q <= 1'b0;
            b2c_q <= 1'b0;
            mopen_q <= 1'b0;
            mclose_q <= 1'b0;
            fail_q <= 1'b0;
            foreign_q <= 1'b0;
            sel_in_q <= 1'b0;
            cblk_q <= 1'b0;
            sblk_q <= 5'h00;
        end else begin
            req_q <= {reclose_request_four_in, reclose_request_three_in,
                      reclose_request_two_in, reclose_request_one_in}; // R24
            crit_q <= critical_request_in;
            b1c_q <= breaker_one_closed_in;
            b2c_q <= breaker_two_closed_in;
            mopen_q <= manual_open_in;
            mclose_q <= manual_close_in;
            fail_q <= breaker_fail_in;
            foreign_q <= foreign_operation_in;
            sel_in_q <= second_breaker_select_input_in;
            cblk_q <= close_block_in;
            sblk_q <= shot_block_in;
        end
    end

    //------------------------------------------------------------
    // apb register file
    //------------------------------------------------------------
    reg [15:0] cfg [0:27];
    wire [4:0] idx = paddr_in[6:2];
    wire mapped = (paddr_in[31:7] == 25'h0) && (idx <= `ARSEQ_IDX_LAST);
    wire [31:0] status_w;
    integer k;
    assign pready_out = 1'b1;
    // zero wait states: read data is captured in the setup cycle
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (k = 0; k < 28; k = k + 1) begin
                cfg[k] <= `ARSEQ_RST_SETTING;
            end
            cfg[`ARSEQ_IDX_CTRL] <= `ARSEQ_RST_CTRL;
            cfg[`ARSEQ_IDX_TICKDIV] <= `ARSEQ_RST_TICKDIV;
            prdata_out <= 32'h0;
            pslverr_out <= 1'b0;
        end else begin
            if (psel_in && !penable_in) begin
                pslverr_out <= !mapped;
                if (!mapped) begin
                    prdata_out <= 32'h0;
                end else if (idx == `ARSEQ_IDX_STATUS) begin
                    prdata_out <= status_w;
                end else begin
                    prdata_out <= {16'h0, cfg[idx]};
                end
            end
            if (psel_in && penable_in && pwrite_in && mapped && (idx != `ARSEQ_IDX_STATUS)) begin
                cfg[idx] <= pwdata_in[15:0];
            end
        end
    end

    wire ar_enable = cfg[`ARSEQ_IDX_CTRL][`ARSEQ_CTRL_ENABLE];
    wire shot_recl = cfg[`ARSEQ_IDX_CTRL][`ARSEQ_CTRL_SHOT_RECL];
    wire auto_brk = cfg[`ARSEQ_IDX_CTRL][`ARSEQ_CTRL_AUTO_BRK];

    //------------------------------------------------------------
    // common timebase tick
    //------------------------------------------------------------
    reg [15:0] div_q;
    wire tick = (div_q >= cfg[`ARSEQ_IDX_TICKDIV]);
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_q <= 16'h0;
        end else begin
            div_q <= tick ? 16'h0 : div_q + 16'h1; // R23
        end
    end

    //------------------------------------------------------------
    // breaker choice
    //------------------------------------------------------------
    wire cur_closed = second_breaker_out ? b2c_q : b1c_q;
    reg want_second;
    always @* begin
        if (auto_brk) begin
            want_second = (b2c_q && !b1c_q) ? 1'b1 : (b1c_q ? 1'b0 : second_breaker_out);
        end else begin
            want_second = sel_in_q;
        end
    end
    // a closed breaker keeps control; the object may change only while it is open
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            second_breaker_out <= 1'b0;
        end else if (!cur_closed) begin
            second_breaker_out <= want_second; // R16
        end
    end

    //------------------------------------------------------------
    // per-line enables, first shots and start-delay counters
    //------------------------------------------------------------
    wire [4:0] line_en [0:3];
    wire [2:0] first [0:3];
    wire [15:0] sdelay [0:3];
    wire [3:0] sdone;
    reg [15:0] scnt_q [0:3];
    reg [7:0] state_q;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_line
            assign line_en[g] = {cfg[`ARSEQ_IDX_SHOTEN0 + 4][g], cfg[`ARSEQ_IDX_SHOTEN0 + 3][g],
                                 cfg[`ARSEQ_IDX_SHOTEN0 + 2][g], cfg[`ARSEQ_IDX_SHOTEN0 + 1][g],
                                 cfg[`ARSEQ_IDX_SHOTEN0][g]} & ~sblk_q; // R01 R17
            assign first[g] = next_shot(line_en[g], 3'h0);
            // later first shot takes the previous shot's discrimination time
            assign sdelay[g] = (first[g] == 3'h0 || first[g] == `ARSEQ_NO_SHOT) ?
                               cfg[`ARSEQ_IDX_START0 + g] :
                               cfg[`ARSEQ_IDX_DISCR0 + first[g] - 3'h1]; // R18
            assign sdone[g] = req_q[g] && (scnt_q[g] >= sdelay[g]);
            always @(posedge clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    scnt_q[g] <= 16'h0;
                end else if (!req_q[g] || !(state_q == ST_START)) begin
                    scnt_q[g] <= 16'h0;
                end else if (tick && !sdone[g]) begin
                    scnt_q[g] <= scnt_q[g] + 16'h1; // R04 R23
                end
            end
        end
    endgenerate

    // highest-priority active line governs; lower lines wait behind it
    reg [1:0] top_line;
    always @* begin
        top_line = 2'd3;
        if (req_q[2]) top_line = 2'd2;
        if (req_q[1]) top_line = 2'd1;
        if (req_q[0]) top_line = 2'd0; // R02 R05
    end

    //------------------------------------------------------------
    // sequencer
    //------------------------------------------------------------
    reg [2:0] shot_q;
    reg [1:0] line_q;
    reg manual_q;
    reg [15:0] tmr_q;
    reg [24:0] ft_cnt_q;
    wire [4:0] cur_en = line_en[line_q];
    wire [2:0] adv = (shot_q == 3'h4) ? `ARSEQ_NO_SHOT : next_shot(cur_en, shot_q + 3'h1);
    wire [15:0] recl_lim = (manual_q || !shot_recl) ? cfg[`ARSEQ_IDX_RECLAIM] :
                           cfg[`ARSEQ_IDX_SRECL0 + shot_q]; // R12
    wire [15:0] dead_lim = cfg[`ARSEQ_IDX_DEAD0 + shot_q];
    wire [15:0] discr_lim = cfg[`ARSEQ_IDX_DISCR0 + shot_q];
    wire running_seq = !(state_q == ST_IDLE) && !(state_q == ST_LOCK) && !manual_q;
    wire tmr_run = tick && (state_q == ST_DEAD || state_q == ST_DISCR || state_q == ST_RECL);

    assign status_w = {8'h0, final_trip_out, shot_active_out, running_out, locked_out,
                       second_breaker_out, shot_q, state_q};

    // main sequence; aborts take priority over the shot flow
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= ST_IDLE;
            shot_q <= 3'h0;
            line_q <= 2'd0;
            manual_q <= 1'b0;
            tmr_q <= 16'h0;
            open_cmd_out <= 1'b0;
            close_cmd_out <= 1'b0;
            shot_active_out <= 5'h00;
            running_out <= 1'b0;
            locked_out <= 1'b0;
            final_trip_out <= 5'h00;
            ft_cnt_q <= 25'h0;
        end else begin
            if (tmr_run) begin
                tmr_q <= tmr_q + 16'h1; // R23
            end
            // final-trip flags hold for a fixed time, then clear together
            if (final_trip_out != 5'h00) begin
                if (ft_cnt_q >= FT_HOLD_CYC - 25'h1) begin
                    final_trip_out <= 5'h00; // R21
                    ft_cnt_q <= 25'h0;
                end else begin
                    ft_cnt_q <= ft_cnt_q + 25'h1;
                end
            end
            if (running_seq && (mopen_q || fail_q || foreign_q)) begin
                state_q <= ST_IDLE; // R14 R15
                open_cmd_out <= 1'b0;
                close_cmd_out <= 1'b0;
                running_out <= 1'b0;
                shot_active_out <= 5'h00;
            end else if (running_seq && crit_q && (state_q == ST_DEAD || state_q == ST_CLOSE ||
                         state_q == ST_DISCR)) begin // R09
                state_q <= ST_LOCK; // R08
                locked_out <= 1'b1;
                open_cmd_out <= cur_closed;
                close_cmd_out <= 1'b0;
                running_out <= 1'b0;
                shot_active_out <= 5'h00;
                final_trip_out <= 5'h10; // R21
                ft_cnt_q <= 25'h0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (mclose_q) begin
                            state_q <= ST_RECL; // R13
                            manual_q <= 1'b1;
                            tmr_q <= 16'h0;
                        end else if (ar_enable && (req_q != 4'h0)) begin
                            if (first[top_line] == `ARSEQ_NO_SHOT) begin
                                state_q <= ST_LOCK; // R03
                                locked_out <= 1'b1;
                                open_cmd_out <= cur_closed;
                                final_trip_out <= 5'h01 << top_line;
                                ft_cnt_q <= 25'h0;
                            end else begin
                                state_q <= ST_START;
                            end
                        end
                    end
                    ST_START: begin
                        if (req_q == 4'h0) begin
                            state_q <= ST_IDLE;
                        end else if (sdone[top_line]) begin
                            line_q <= top_line; // R04
                            shot_q <= first[top_line];
                            shot_active_out <= 5'h01 << first[top_line]; // R19
                            open_cmd_out <= cur_closed; // R06
                            state_q <= ST_OPEN;
                        end
                    end
                    ST_OPEN: begin
                        if (!cur_closed) begin
                            open_cmd_out <= 1'b0;
                            running_out <= 1'b1; // R20
                            tmr_q <= 16'h0;
                            state_q <= ST_DEAD; // R06
                        end
                    end
                    ST_DEAD: begin
                        // the close is held back while close blocking stands
                        if (tmr_q >= dead_lim && !cblk_q) begin
                            close_cmd_out <= 1'b1; // R07 R22
                            running_out <= 1'b0; // R20
                            state_q <= ST_CLOSE;
                        end
                    end
                    ST_CLOSE: begin
                        if (cur_closed) begin
                            close_cmd_out <= 1'b0;
                            tmr_q <= 16'h0;
                            state_q <= ST_DISCR; // R07
                        end
                    end
                    ST_DISCR, ST_RECL: begin
                        if (!manual_q && (req_q != 4'h0)) begin
                            if (adv == `ARSEQ_NO_SHOT) begin
                                state_q <= ST_LOCK; // R17
                                locked_out <= 1'b1;
                                open_cmd_out <= cur_closed;
                                shot_active_out <= 5'h00;
                                final_trip_out <= 5'h01 << line_q;
                                ft_cnt_q <= 25'h0;
                            end else begin
                                shot_q <= adv; // R10
                                shot_active_out <= 5'h01 << adv; // R19
                                open_cmd_out <= cur_closed;
                                state_q <= ST_OPEN;
                            end
                        end else if (state_q == ST_DISCR && tmr_q >= discr_lim) begin
                            tmr_q <= 16'h0;
                            state_q <= ST_RECL; // R10
                        end else if (state_q == ST_RECL && tmr_q >= recl_lim) begin
                            state_q <= ST_IDLE; // R11
                            manual_q <= 1'b0;
                            shot_q <= 3'h0;
                            shot_active_out <= 5'h00; // R19
                        end
                    end
                    ST_LOCK: begin
                        if (!cur_closed) begin
                            open_cmd_out <= 1'b0;
                        end
                        if (mclose_q) begin
                            locked_out <= 1'b0; // R08
                            open_cmd_out <= 1'b0;
                            manual_q <= 1'b1;
                            tmr_q <= 16'h0;
                            state_q <= ST_RECL;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // arseq_core
`default_nettype wire

// file: verif/arseq_core_monitor.sv
// concurrent checks on the reclose sequencer ports
`timescale 1ns/1ps
`default_nettype none
module arseq_core_monitor #(
    parameter [24:0] FT_HOLD_CYC = 25'd50
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic manual_close_in,
    input wire logic close_block_in,
    input wire logic breaker_one_closed_in,
    input wire logic breaker_two_closed_in,
    input wire logic open_cmd_out,
    input wire logic close_cmd_out,
    input wire logic second_breaker_out,
    input wire logic [4:0] shot_active_out,
    input wire logic running_out,
    input wire logic [4:0] final_trip_out,
    input wire logic locked_out
);
    // -------------------------------------------------
    // helpers and properties
    // -------------------------------------------------
    // position of whichever breaker is under control
    wire logic sel_closed = second_breaker_out ? breaker_two_closed_in : breaker_one_closed_in;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    a_cmd_exclusive: assert property (!(open_cmd_out && close_cmd_out)) else $error("open and close together");
    a_open_cause: assert property ($rose(open_cmd_out) |-> $past(sel_closed)) else $error("open on open breaker");
    a_run_start: assert property ($rose(running_out) |-> !$past(sel_closed)) else $error("running while closed");
    a_run_close: assert property (close_cmd_out |-> !running_out) else $error("running during close");
    a_close_blocked: assert property ($rose(close_cmd_out) |-> !($past(close_block_in) && $past(close_block_in, 2)))
        else $error("close issued while blocked");
    a_shot_onehot: assert property ($onehot0(shot_active_out)) else $error("several shots active");
    a_run_shot: assert property (running_out |-> |shot_active_out) else $error("running without shot");
    a_lock_quiet: assert property (locked_out |-> !running_out && !close_cmd_out) else $error("activity in lock");
    a_lock_trip: assert property ($rose(locked_out) |-> ##[0:1] (|final_trip_out)) else $error("lock without trip");
    a_lock_leave: assert property ($fell(locked_out) |-> $past(manual_close_in) || $past(manual_close_in, 2))
        else $error("lock left without manual close");
    // per-flag high time, each bit alone
    for (genvar i = 0; i < 5; i++) begin : g_ft
        logic [24:0] cnt_q;
        always_ff @(posedge clk_in or negedge arst_n_in) begin
            if (!arst_n_in) cnt_q <= 25'h0;
            else cnt_q <= final_trip_out[i] ? cnt_q + 25'h1 : 25'h0;
        end
        a_ft_hold: assert property ($fell(final_trip_out[i]) |-> cnt_q >= FT_HOLD_CYC - 1 && cnt_q <= FT_HOLD_CYC + 1)
            else $error("final trip hold wrong");
    end
    c_lock: cover property ($rose(locked_out));
    c_success: cover property ($fell(shot_active_out[0]) && !locked_out);
    c_trip: cover property ($rose(final_trip_out[3]));
endmodule // arseq_core_monitor
bind arseq_core arseq_core_monitor #(.FT_HOLD_CYC(FT_HOLD_CYC)) u_mon (.*);
`default_nettype wire

// file: verif/arseq_breaker_model.sv
// behavioural breaker pair answering open and close commands
`timescale 1ns/1ps
`default_nettype none
module arseq_breaker_model (
    input wire logic clk_in,
    input wire logic open_cmd_in,
    input wire logic close_cmd_in,
    input wire logic second_in,
    input wire logic slow_in,
    input wire logic force_close_in,
    output logic one_closed_out,
    output logic two_closed_out
);
    // -------------------------------------------------
    // mechanism
    // -------------------------------------------------
    logic one_q = 1'b1;
    logic two_q = 1'b0;
    logic [3:0] wait_q = 4'h0;
    wire logic pos = second_in ? two_q : one_q;
    wire logic move = (open_cmd_in && pos) || (close_cmd_in && !pos);
    // slow mode makes the sequencer wait on feedback
    always @(posedge clk_in) begin
        if (force_close_in || (move && wait_q >= (slow_in ? 4'h6 : 4'h1))) begin
            if (second_in) two_q <= force_close_in | ~two_q;
            else one_q <= force_close_in | ~one_q;
            wait_q <= 4'h0;
        end else wait_q <= move ? wait_q + 4'h1 : 4'h0;
    end
    assign one_closed_out = one_q;
    assign two_closed_out = two_q;
endmodule // arseq_breaker_model
`default_nettype wire

// file: verif/breaker_auto_reclose_sequencer_tb.sv
// self-checking bench for the reclose sequencer
`timescale 1ns/1ps
`default_nettype none
`include "arseq_map.vh"
module breaker_auto_reclose_sequencer_tb;
    // -------------------------------------------------
    // signals, clock and instances
    // -------------------------------------------------
    logic clk_in = 0, arst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic [31:0] paddr_in = 0, pwdata_in = 0, rd;
    logic critical_request_in = 0, manual_open_in = 0, manual_close_in = 0, breaker_fail_in = 0;
    logic foreign_operation_in = 0, second_breaker_select_input_in = 0, close_block_in = 0, slow_q = 0, er;
    logic [4:0] shot_block_in = 0;
    logic [3:0] req_q = 0;
    wire pready_out, pslverr_out, open_cmd_out, close_cmd_out, second_breaker_out, running_out, locked_out;
    wire breaker_one_closed_in, breaker_two_closed_in;
    wire [31:0] prdata_out;
    wire [4:0] shot_active_out, final_trip_out;
    wire reclose_request_one_in = req_q[0];
    wire reclose_request_two_in = req_q[1];
    wire reclose_request_three_in = req_q[2];
    wire reclose_request_four_in = req_q[3];
    int err_count = 0, checks = 0, i;
    always #12.5 clk_in = ~clk_in;
    arseq_core #(.FT_HOLD_CYC(25'd50)) u_dut (.*);
    arseq_breaker_model u_brk (.clk_in, .open_cmd_in(open_cmd_out), .close_cmd_in(close_cmd_out),
        .second_in(second_breaker_out), .slow_in(slow_q), .force_close_in(manual_close_in),
        .one_closed_out(breaker_one_closed_in), .two_closed_out(breaker_two_closed_in));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one apb transfer, held until pready at a rising edge
    task automatic apb(input logic w, input logic [4:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= {25'h0, idx, 2'b00};
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    // bounded wait on an output level at the falling edge
    task automatic wt(input int s, input logic v);
        logic c;
        int n;
        for (n = 0; n < 600; n++) begin
            @(negedge clk_in);
            case (s)
                0: c = open_cmd_out;
                1: c = running_out;
                2: c = close_cmd_out;
                3: c = |shot_active_out;
                4: c = locked_out;
                default: c = |final_trip_out;
            endcase
            if (c === v) break;
        end
        if (n == 600) begin
            chk(0, 1);
            summarize();
        end
    endtask
    // one full shot; blk holds close blocking over the end of the dead time
    task automatic seq(input logic [3:0] req, input logic blk);
        logic bad;
        bad = 0;
        // blocking must stand before the dead time can end
        @(posedge clk_in) req_q <= req;
        close_block_in <= blk;
        wt(0, 1);
        chk(shot_active_out, 5'h01);
        chk(final_trip_out, 5'h00);
        @(posedge clk_in) req_q <= 4'h0;
        wt(1, 1);
        if (blk) begin
            repeat (30) @(negedge clk_in) bad = bad | close_cmd_out;
            chk(bad, 0);
            @(posedge clk_in) close_block_in <= 1'b0;
        end
        wt(2, 1);
        chk(running_out, 0);
        wt(3, 0);
        apb(0, `ARSEQ_IDX_STATUS, 0);
        chk(rd[7:0], 8'h01);
    endtask
    // -------------------------------------------------
    // main sequence
    // -------------------------------------------------
    initial begin
        void'($urandom(32'hb627));
        repeat (8) @(posedge clk_in);
        arst_n_in <= 1'b1;
        apb(0, `ARSEQ_IDX_CTRL, 0);
        chk(rd, 32'h10);
        apb(0, `ARSEQ_IDX_TICKDIV, 0);
        chk(rd, 32'h9c3f);
        apb(0, 5'h1c, 0);
        chk(er, 1);
        chk(rd, 0);
        for (i = 4; i < 23; i++) apb(1, i[4:0], $urandom_range(4, 1));
        apb(1, `ARSEQ_IDX_SHOTEN0, 32'h7);
        for (i = 24; i < 28; i++) apb(1, i[4:0], 0);
        apb(1, `ARSEQ_IDX_RECLAIM, 32'd40);
        apb(1, `ARSEQ_IDX_TICKDIV, 32'h1);
        apb(1, `ARSEQ_IDX_CTRL, 32'h11);
        slow_q <= $urandom_range(1, 0);
        seq(4'b1001, 0);
        slow_q <= $urandom_range(1, 0);
        seq(4'b0001, 1);
        // critical with nothing running must do nothing
        @(posedge clk_in) critical_request_in <= 1'b1;
        repeat (20) @(posedge clk_in);
        chk({locked_out, final_trip_out}, 6'h00);
        critical_request_in <= 1'b0;
        // critical inside dead time locks, manual close releases into reclaim
        req_q <= 4'h1;
        wt(1, 1);
        @(posedge clk_in) req_q <= 4'h0;
        critical_request_in <= 1'b1;
        wt(4, 1);
        chk(final_trip_out, 5'h10);
        @(posedge clk_in) critical_request_in <= 1'b0;
        manual_close_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        manual_close_in <= 1'b0;
        wt(4, 0);
        apb(0, `ARSEQ_IDX_STATUS, 0);
        chk(rd[7:0], 8'h40);
        req_q <= 4'h1;
        repeat (20) @(negedge clk_in) er = er | open_cmd_out;
        chk(er, 0);
        @(posedge clk_in) req_q <= 4'h0;
        repeat (120) @(posedge clk_in);
        apb(0, `ARSEQ_IDX_STATUS, 0);
        chk({final_trip_out, rd[7:0]}, 13'h0001);
        // a line that enables no shot trips at once
        @(posedge clk_in) req_q <= 4'h8;
        wt(5, 1);
        chk(final_trip_out, 5'h08);
        @(posedge clk_in) req_q <= 4'h0;
        wt(5, 0);
        summarize();
    end
endmodule // breaker_auto_reclose_sequencer_tb
`default_nettype wire
